//--- inc/frtoc_pkg.sv
package frtoc_pkg;
   // ==========================================================
   // register map (byte addresses, one aligned word each)
   // ==========================================================
   localparam logic [5:0] ADDR_CTRL_ONE = 6'h00; // timer_control_one
   localparam logic [5:0] ADDR_CTRL_TWO = 6'h04; // timer_control_two
   localparam logic [5:0] ADDR_STATUS = 6'h08; // timer_status_flags
   localparam logic [5:0] ADDR_CMP1_HI = 6'h0c;
   localparam logic [5:0] ADDR_CMP1_LO = 6'h10;
   localparam logic [5:0] ADDR_CMP2_HI = 6'h14;
   localparam logic [5:0] ADDR_CMP2_LO = 6'h18;
   localparam logic [5:0] ADDR_CNT_HI = 6'h1c;
   localparam logic [5:0] ADDR_CNT_LO = 6'h20;
   localparam logic [5:0] ADDR_SHD_HI = 6'h24;
   localparam logic [5:0] ADDR_SHD_LO = 6'h28;
   localparam logic [5:0] ADDR_MODE = 6'h2c; // bit0: external clock select

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int C1_COMPARE_IRQ_ENABLE = 6;
   localparam int C1_OVERFLOW_IRQ_ENABLE = 5;
   localparam int C1_FOLV2 = 4;
   localparam int C1_FOLV1 = 3;
   localparam int C1_OLVL2 = 2;
   localparam int C1_OLVL1 = 0;
   localparam int C2_OC1E = 7;
   localparam int C2_OC2E = 6;
   localparam int C2_CC_LO = 2;
   localparam int C2_CC_HI = 3;
   localparam int ST_OCF1 = 6;
   localparam int ST_TOF = 5;
   localparam int ST_OCF2 = 3;
   localparam int MODE_EXT = 0;

   // ==========================================================
   // values
   // ==========================================================
   localparam logic [15:0] CNT_RELOAD = 16'hfffc;
   localparam logic [15:0] CNT_TOP = 16'hffff;
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] CMP_LATE = 16'h0001; // late-match offset for slow clocks
   localparam logic [1:0] CC_DIV4 = 2'h0;
   localparam logic [1:0] CC_DIV2 = 2'h1;
   localparam logic [1:0] CC_DIV8 = 2'h2;
   localparam logic [2:0] PSC_LAST2 = 3'h1;
   localparam logic [2:0] PSC_LAST4 = 3'h3;
   localparam logic [2:0] PSC_LAST8 = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : frtoc_pkg

//--- rtl/frtoc_timer.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module frtoc_timer (
   input wire logic mclk,
   input wire logic srst,
   input wire logic halt_mode,
   input wire logic ext_timer_clk,
   output logic [1:0] compare_output_pin,
   output logic [1:0] compare_output_pin_oe,
   output logic timer_irq,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [5:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic ext_sel;
      logic [15:0] cnt;
      logic [2:0] psc;
      logic [15:0] cmp1;
      logic [15:0] cmp0;
      logic [1:0] inhibit;
      logic overflow_flag;
      logic [1:0] compare_match_flag;
      logic arm_tof;
      logic [1:0] arm_ocf;
      logic [7:0] buf_main;
      logic pend_main;
      logic [7:0] buf_shd;
      logic pend_shd;
      logic [1:0] pin;
      logic [2:0] sync;
      logic ext_lvl;
      logic aw_full;
      logic [5:0] aw_addr;
      logic w_full;
      logic [7:0] wdata;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } frtoc_state_s;

   frtoc_state_s st_q;
   frtoc_state_s st_d;

   // true for any address the map decodes; used by read and write paths
   function automatic logic frtoc_mapped(input logic [5:0] a);
      frtoc_mapped = (a[1:0] == 2'h0) && (a <= frtoc_pkg::ADDR_MODE);
   endfunction : frtoc_mapped

   // ==========================================================
   // outputs
   // ==========================================================
   assign s_axi_awready = !st_q.aw_full && !st_q.bvalid;
   assign s_axi_wready = !st_q.w_full && !st_q.bvalid;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = {24'h000000, st_q.rdata};
   assign s_axi_rresp = st_q.rresp;
   assign compare_output_pin = st_q.pin;
   // pin released to general i/o when its enable is clear
   assign compare_output_pin_oe = {st_q.ctrl_two[frtoc_pkg::C2_OC2E],
                                   st_q.ctrl_two[frtoc_pkg::C2_OC1E]};
   // single request line; pending until software clears the flag
   assign timer_irq = (st_q.overflow_flag && st_q.ctrl_one[frtoc_pkg::C1_OVERFLOW_IRQ_ENABLE])
                    || ((|st_q.compare_match_flag)
                        && st_q.ctrl_one[frtoc_pkg::C1_COMPARE_IRQ_ENABLE]);

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      logic tick;
      logic [2:0] psc_last;
      logic psc_ok;
      logic [15:0] cnt_inc;
      logic [15:0] target;
      logic [15:0] cmp_v;
      logic [1:0] level;
      logic [1:0] force_on;
      logic [1:0] pin_en;
      logic [1:0] ocf_set;
      logic tof_set;
      logic aw_go;
      logic w_go;
      logic wr_go;
      logic rd_go;
      logic [5:0] ra;
      logic [5:0] wa;
      logic [7:0] wd;
      tick = 1'b0;
      psc_last = frtoc_pkg::PSC_LAST4;
      psc_ok = 1'b1;
      cnt_inc = st_q.cnt + 16'h0001;
      target = 16'h0000;
      cmp_v = 16'h0000;
      level = {st_q.ctrl_one[frtoc_pkg::C1_OLVL2], st_q.ctrl_one[frtoc_pkg::C1_OLVL1]};
      force_on = {st_q.ctrl_one[frtoc_pkg::C1_FOLV2], st_q.ctrl_one[frtoc_pkg::C1_FOLV1]};
      pin_en = compare_output_pin_oe;
      ocf_set = 2'h0;
      tof_set = 1'b0;
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      wr_go = st_q.aw_full && st_q.w_full && !st_q.bvalid;
      rd_go = s_axi_arvalid && s_axi_arready;
      ra = s_axi_araddr;
      wa = st_q.aw_addr;
      wd = st_q.wdata;
      st_d = st_q;

      // external clock: three stages, a change counts when stages two and three agree
      st_d.sync = {st_q.sync[1:0], ext_timer_clk};
      if ((st_q.sync[1] == st_q.sync[2]) && (st_q.sync[2] != st_q.ext_lvl)) begin
         st_d.ext_lvl = st_q.sync[2];
      end

      // prescaler select; the reserved code holds the counter still on the internal clock
      unique case (st_q.ctrl_two[frtoc_pkg::C2_CC_HI:frtoc_pkg::C2_CC_LO])
         frtoc_pkg::CC_DIV4: psc_last = frtoc_pkg::PSC_LAST4;
         frtoc_pkg::CC_DIV2: psc_last = frtoc_pkg::PSC_LAST2;
         frtoc_pkg::CC_DIV8: psc_last = frtoc_pkg::PSC_LAST8;
         default: psc_ok = 1'b0;
      endcase

      // timer tick; halt freezes prescaler and count, wait is not seen here
      if (!halt_mode) begin
         if (st_q.ext_sel) begin
            tick = (st_q.sync[1] == st_q.sync[2]) && st_q.sync[2] && !st_q.ext_lvl;
         end else if (psc_ok) begin
            if (st_q.psc >= psc_last) begin
               st_d.psc = 3'h0;
               tick = 1'b1;
            end else begin
               st_d.psc = st_q.psc + 3'h1;
            end
         end
      end

      // free-running count and wrap detection
      if (tick) begin
         st_d.cnt = cnt_inc;
         tof_set = (st_q.cnt == frtoc_pkg::CNT_TOP);
      end

      // compare channels, checked against the new count on every tick while the channel's inhibit bit is clear
      for (int i = 0; i < 2; i++) begin
         cmp_v = (i == 0) ? st_q.cmp0 : st_q.cmp1;
         // divide-by-2 matches at equality, slower clocks one count later
         if (!st_q.ext_sel
             && st_q.ctrl_two[frtoc_pkg::C2_CC_HI:frtoc_pkg::C2_CC_LO] == frtoc_pkg::CC_DIV2) begin
            target = cmp_v;
         end else begin
            target = cmp_v + frtoc_pkg::CMP_LATE;
         end
         if (tick && !st_q.inhibit[i] && cnt_inc == target) begin
            ocf_set[i] = 1'b1;
            if (pin_en[i]) begin
               st_d.pin[i] = level[i];
            end
         end
         // forcing drives the level only, leaves the flag alone
         if (force_on[i] && pin_en[i]) begin
            st_d.pin[i] = level[i];
         end
      end

      // ==========================================================
      // bus write channel
      // ==========================================================
      if (aw_go) begin
         st_d.aw_full = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (w_go) begin
         st_d.w_full = 1'b1;
         st_d.wdata = s_axi_wdata[7:0];
         st_d.w_lane0 = s_axi_wstrb[0];
      end
      if (wr_go) begin
         st_d.aw_full = 1'b0;
         st_d.w_full = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = frtoc_mapped(wa) ? frtoc_pkg::RESP_OKAY : frtoc_pkg::RESP_SLVERR;
         // an access with lane 0 off changes nothing
         if (st_q.w_lane0) begin
            unique case (wa)
               frtoc_pkg::ADDR_CTRL_ONE: st_d.ctrl_one = wd & 8'h7d;
               frtoc_pkg::ADDR_CTRL_TWO: st_d.ctrl_two = wd & 8'hcc;
               frtoc_pkg::ADDR_MODE: st_d.ext_sel = wd[frtoc_pkg::MODE_EXT];
               frtoc_pkg::ADDR_CMP1_HI: begin
                  st_d.cmp0[15:8] = wd;
                  st_d.inhibit[0] = 1'b1;
               end
               frtoc_pkg::ADDR_CMP2_HI: begin
                  st_d.cmp1[15:8] = wd;
                  st_d.inhibit[1] = 1'b1;
               end
               frtoc_pkg::ADDR_CMP1_LO: begin
                  st_d.cmp0[7:0] = wd;
                  st_d.inhibit[0] = 1'b0;
               end
               frtoc_pkg::ADDR_CMP2_LO: begin
                  st_d.cmp1[7:0] = wd;
                  st_d.inhibit[1] = 1'b0;
               end
               frtoc_pkg::ADDR_CNT_LO, frtoc_pkg::ADDR_SHD_LO: begin
                  st_d.cnt = frtoc_pkg::CNT_RELOAD;
                  st_d.psc = 3'h0;
               end
               default: ;
            endcase
         end
         // writing the low byte also serves as the second clearing step
         if (st_q.w_lane0 && wa == frtoc_pkg::ADDR_CNT_LO && st_q.arm_tof) begin
            st_d.overflow_flag = 1'b0;
            st_d.arm_tof = 1'b0;
         end
         if (st_q.w_lane0 && wa == frtoc_pkg::ADDR_CMP1_LO && st_q.arm_ocf[0]) begin
            st_d.compare_match_flag[0] = 1'b0;
            st_d.arm_ocf[0] = 1'b0;
         end
         if (st_q.w_lane0 && wa == frtoc_pkg::ADDR_CMP2_LO && st_q.arm_ocf[1]) begin
            st_d.compare_match_flag[1] = 1'b0;
            st_d.arm_ocf[1] = 1'b0;
         end
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      // ==========================================================
      // bus read channel; side effects happen when the address is taken
      // ==========================================================
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (rd_go) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = frtoc_mapped(ra) ? frtoc_pkg::RESP_OKAY : frtoc_pkg::RESP_SLVERR;
         st_d.rdata = 8'h00;
         unique case (ra)
            frtoc_pkg::ADDR_CTRL_ONE: st_d.rdata = st_q.ctrl_one;
            frtoc_pkg::ADDR_CTRL_TWO: st_d.rdata = st_q.ctrl_two;
            frtoc_pkg::ADDR_MODE: st_d.rdata = {7'h00, st_q.ext_sel};
            frtoc_pkg::ADDR_STATUS: begin
               st_d.rdata[frtoc_pkg::ST_OCF1] = st_q.compare_match_flag[0];
               st_d.rdata[frtoc_pkg::ST_TOF] = st_q.overflow_flag;
               st_d.rdata[frtoc_pkg::ST_OCF2] = st_q.compare_match_flag[1];
               // first clearing step: arm only the flags seen set
               st_d.arm_tof = st_q.arm_tof || st_q.overflow_flag;
               st_d.arm_ocf = st_q.arm_ocf | st_q.compare_match_flag;
            end
            frtoc_pkg::ADDR_CMP1_HI: st_d.rdata = st_q.cmp0[15:8];
            frtoc_pkg::ADDR_CMP2_HI: st_d.rdata = st_q.cmp1[15:8];
            frtoc_pkg::ADDR_CMP1_LO: begin
               st_d.rdata = st_q.cmp0[7:0];
               if (st_q.arm_ocf[0]) begin
                  st_d.compare_match_flag[0] = 1'b0;
                  st_d.arm_ocf[0] = 1'b0;
               end
            end
            frtoc_pkg::ADDR_CMP2_LO: begin
               st_d.rdata = st_q.cmp1[7:0];
               if (st_q.arm_ocf[1]) begin
                  st_d.compare_match_flag[1] = 1'b0;
                  st_d.arm_ocf[1] = 1'b0;
               end
            end
            // high read freezes the low byte; repeat reads keep the first copy
            frtoc_pkg::ADDR_CNT_HI: begin
               st_d.rdata = st_q.cnt[15:8];
               if (!st_q.pend_main) begin
                  st_d.buf_main = st_q.cnt[7:0];
                  st_d.pend_main = 1'b1;
               end
            end
            frtoc_pkg::ADDR_SHD_HI: begin
               st_d.rdata = st_q.cnt[15:8];
               if (!st_q.pend_shd) begin
                  st_d.buf_shd = st_q.cnt[7:0];
                  st_d.pend_shd = 1'b1;
               end
            end
            frtoc_pkg::ADDR_CNT_LO: begin
               st_d.rdata = st_q.pend_main ? st_q.buf_main : st_q.cnt[7:0];
               st_d.pend_main = 1'b0;
               if (st_q.arm_tof) begin
                  st_d.overflow_flag = 1'b0;
                  st_d.arm_tof = 1'b0;
               end
            end
            // the shadow low byte never touches the overflow flag
            frtoc_pkg::ADDR_SHD_LO: begin
               st_d.rdata = st_q.pend_shd ? st_q.buf_shd : st_q.cnt[7:0];
               st_d.pend_shd = 1'b0;
            end
            default: ;
         endcase
      end

      // hardware sets come last so a set beats a clear in the same cycle
      if (tof_set) begin
         st_d.overflow_flag = 1'b1;
      end
      st_d.compare_match_flag = st_d.compare_match_flag | ocf_set;
   end

   // ==========================================================
   // registers
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
         st_q.cnt <= frtoc_pkg::CNT_RELOAD;
         st_q.cmp0 <= frtoc_pkg::CMP_RESET;
         st_q.cmp1 <= frtoc_pkg::CMP_RESET;
         st_q.pin <= 2'h0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule : frtoc_timer

//--- bench/frtoc_chk.sv
`timescale 1ns/1ps
module frtoc_chk (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [1:0] compare_output_pin,
   input wire logic [1:0] compare_output_pin_oe,
   input wire logic timer_irq,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   // =====
   // handshake steps
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_end;
      s_axi_bvalid && s_axi_bready;
   endsequence
   // =====
   // checks on the ports
   reset_vals_a:
      assert property (disable iff (1'b0) srst |=> compare_output_pin == 2'h0
         && compare_output_pin_oe == 2'h0 && !timer_irq && !s_axi_rvalid && !s_axi_bvalid)
      else $error("outputs not cleared by reset");
   rd_answer_a:
      assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
   rd_upper_a:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   // arready follows rvalid directly, so the port reopens as the answer is retired
   rd_done_a:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not retired");
   ar_ready_a:
      assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
   // both halves are held for one cycle before the register lands and bvalid rises
   wr_answer_a:
      assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write not answered");
   wr_done_a:
      assert property (wr_end |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write answer not retired");
   // flags only drop on a bus access, so the request can only fall then
   irq_fall_a:
      assert property ($fell(timer_irq) |-> s_axi_rvalid || s_axi_bvalid)
      else $error("request dropped without access");
   // a released pin must not pick up the compare level
   pin_quiet_a:
      assert property (!$past(srst) |-> ((compare_output_pin ^ $past(compare_output_pin))
         & ~(compare_output_pin_oe | $past(compare_output_pin_oe))) == 2'h0)
      else $error("released pin changed");
endmodule : frtoc_chk
bind frtoc_timer frtoc_chk i_frtoc_chk (.mclk, .srst, .compare_output_pin,
   .compare_output_pin_oe, .timer_irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- bench/frtoc_far.sv
`timescale 1ns/1ps
module frtoc_far (
   input wire logic ext_run,
   input wire logic [1:0] compare_output_pin,
   input wire logic [1:0] compare_output_pin_oe,
   output logic ext_timer_clk,
   output logic [1:0] pad_level
);
   // =====
   // external timer clock, still unless asked to run; period unrelated to mclk
   initial begin
      ext_timer_clk = 1'b0;
      forever begin
         #85;
         ext_timer_clk = ext_run ? ~ext_timer_clk : 1'b0;
      end
   end
   // pads carry pull-downs, so a released pin reads low
   assign pad_level = compare_output_pin & compare_output_pin_oe;
endmodule : frtoc_far

//--- bench/frtoc_timer_bench.sv
`timescale 1ns/1ps
module frtoc_timer_bench;
   // =====
   // signals
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic halt_mode = 1'b0;
   logic ext_run = 1'b0;
   logic ext_timer_clk, timer_irq;
   logic [1:0] compare_output_pin, compare_output_pin_oe, pad_level;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int fail_count = 0;
   int n_tests = 0;
   frtoc_timer i_frtoc_timer (.mclk, .srst, .halt_mode, .ext_timer_clk, .compare_output_pin,
      .compare_output_pin_oe, .timer_irq, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
   frtoc_far i_frtoc_far (.ext_run, .compare_output_pin, .compare_output_pin_oe,
      .ext_timer_clk, .pad_level);
   // 40 MHz clock
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   // =====
   // bus and report tasks
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   task automatic tmo;
      fail_count++;
      $display("Error wait expected done seen timeout");
      summarize();
   endtask : tmo
   task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", w, e, s);
      end
   endtask : chk
   // one write; each valid drops once its own ready is seen
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      if (n >= 50) tmo();
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] s);
      int n;
      n = 0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      v = s_axi_rdata;
      s = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) tmo();
   endtask : rd
   task automatic rc(input string w, input logic [5:0] a, input logic [7:0] e);
      logic [31:0] v;
      logic [1:0] s;
      rd(a, v, s);
      chk(w, v, {24'h0, e});
   endtask : rc
   // =====
   // scenarios
   task automatic t_reset;
      chk("pins", {compare_output_pin, compare_output_pin_oe, timer_irq}, 32'h0);
      rc("cmp1 hi", frtoc_pkg::ADDR_CMP1_HI, 8'h80);
      rc("cmp1 lo", frtoc_pkg::ADDR_CMP1_LO, 8'h00);
      rc("cmp2 hi", frtoc_pkg::ADDR_CMP2_HI, 8'h80);
      rc("status", frtoc_pkg::ADDR_STATUS, 8'h00);
      rd(6'h30, d, r);
      chk("unmapped", {30'h0, r}, {30'h0, frtoc_pkg::RESP_SLVERR});
      wr(6'h30, 8'h00);
      chk("unmapped wr", {30'h0, r}, {30'h0, frtoc_pkg::RESP_SLVERR});
      $display("test reset done");
   endtask : t_reset
   task automatic t_read;
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h0c);
      wr(frtoc_pkg::ADDR_SHD_LO, 8'h00);
      wr(frtoc_pkg::ADDR_CTRL_ONE, 8'h20);
      rc("count hi", frtoc_pkg::ADDR_CNT_HI, 8'hff);
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h04);
      repeat (40) @(posedge mclk);
      rc("count hi live", frtoc_pkg::ADDR_CNT_HI, 8'h00);
      rc("count lo held", frtoc_pkg::ADDR_CNT_LO, 8'hfc);
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h0c);
      rd(frtoc_pkg::ADDR_SHD_LO, d, r);
      rc("count lo live", frtoc_pkg::ADDR_CNT_LO, d[7:0]);
      rc("shadow hi", frtoc_pkg::ADDR_SHD_HI, 8'h00);
      rc("shadow lo", frtoc_pkg::ADDR_SHD_LO, d[7:0]);
      chk("irq overflow", timer_irq, 1'b1);
      rc("status ovf", frtoc_pkg::ADDR_STATUS, 8'h20);
      rd(frtoc_pkg::ADDR_SHD_LO, d, r);
      rc("status kept", frtoc_pkg::ADDR_STATUS, 8'h20);
      wr(frtoc_pkg::ADDR_CNT_LO, 8'h00);
      @(negedge mclk);
      chk("irq idle", timer_irq, 1'b0);
      rc("status clear", frtoc_pkg::ADDR_STATUS, 8'h00);
      $display("test read done");
   endtask : t_read
   // each mode runs to a match, then halt freezes the count for reading
   task automatic t_match;
      logic [7:0] c2 [4] = '{8'h84, 8'h80, 8'h88, 8'h80};
      logic [15:0] e;
      int k, n;
      for (k = 0; k < 4; k++) begin
         wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h8c);
         wr(frtoc_pkg::ADDR_MODE, {7'h0, k == 3});
         wr(frtoc_pkg::ADDR_CNT_LO, 8'h00);
         wr(frtoc_pkg::ADDR_CMP1_HI, 8'h00);
         wr(frtoc_pkg::ADDR_CMP1_LO, 8'h03);
         wr(frtoc_pkg::ADDR_CTRL_ONE, {1'b0, k == 2, 5'h0, !k[0]});
         ext_run <= (k == 3);
         wr(frtoc_pkg::ADDR_CTRL_TWO, c2[k]);
         n = 0;
         do begin
            @(negedge mclk);
            n++;
         end while (pad_level[0] !== !k[0] && n < 400);
         if (n >= 400) tmo();
         @(posedge mclk);
         halt_mode <= 1'b1;
         ext_run <= 1'b0;
         chk("irq compare", timer_irq, k == 2);
         e = (k == 0) ? 16'h0003 : 16'h0004;
         rc("match hi", frtoc_pkg::ADDR_CNT_HI, e[15:8]);
         rc("match lo", frtoc_pkg::ADDR_CNT_LO, e[7:0]);
         rc("match flags", frtoc_pkg::ADDR_STATUS, 8'h60);
         halt_mode <= 1'b0;
      end
      $display("test match done");
   endtask : t_match
   task automatic t_force;
      wr(frtoc_pkg::ADDR_MODE, 8'h00);
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h8c);
      wr(frtoc_pkg::ADDR_CNT_LO, 8'h00);
      wr(frtoc_pkg::ADDR_CMP1_LO, 8'h03);
      rc("flags cleared", frtoc_pkg::ADDR_STATUS, 8'h00);
      wr(frtoc_pkg::ADDR_CMP1_HI, 8'h00);
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h84);
      repeat (40) @(posedge mclk);
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h8c);
      rc("held off", frtoc_pkg::ADDR_STATUS, 8'h20);
      wr(frtoc_pkg::ADDR_CMP1_LO, 8'h03);
      wr(frtoc_pkg::ADDR_CTRL_ONE, 8'h09);
      @(negedge mclk);
      chk("force high", pad_level[0], 1'b1);
      wr(frtoc_pkg::ADDR_CTRL_ONE, 8'h08);
      @(negedge mclk);
      chk("force low", pad_level[0], 1'b0);
      rc("force no flag", frtoc_pkg::ADDR_STATUS, 8'h20);
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h0c);
      wr(frtoc_pkg::ADDR_CTRL_ONE, 8'h09);
      @(negedge mclk);
      chk("pin released", {compare_output_pin_oe, pad_level}, 4'h0);
      $display("test force done");
   endtask : t_force
   // second channel alone: div2 match at equality drives its own pin and flag
   task automatic t_chan2;
      int n;
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h4c);
      wr(frtoc_pkg::ADDR_CNT_LO, 8'h00);
      wr(frtoc_pkg::ADDR_CMP2_HI, 8'h00);
      wr(frtoc_pkg::ADDR_CMP2_LO, 8'h02);
      chk("write okay", {30'h0, r}, {30'h0, frtoc_pkg::RESP_OKAY});
      wr(frtoc_pkg::ADDR_CTRL_ONE, 8'h04);
      wr(frtoc_pkg::ADDR_CTRL_TWO, 8'h44);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (pad_level[1] !== 1'b1 && n < 400);
      if (n >= 400) tmo();
      @(posedge mclk);
      halt_mode <= 1'b1;
      rc("chan2 lo", frtoc_pkg::ADDR_CNT_LO, 8'h02);
      rc("chan2 flags", frtoc_pkg::ADDR_STATUS, 8'h28);
      rc("chan2 value", frtoc_pkg::ADDR_CMP2_LO, 8'h02);
      halt_mode <= 1'b0;
      $display("test chan2 done");
   endtask : t_chan2
   // =====
   // main sequence
   initial begin
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_read();
      t_match();
      t_force();
      t_chan2();
      summarize();
   end
endmodule : frtoc_timer_bench
